// ### rtl/ahbc_host_port.sv
`timescale 1ns/1ps
module ahbc_host_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic register_select,
  input wire logic byte_select,
  input wire logic cal_b,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic busy_b,
  output logic channel_sel_bit0,
  output logic channel_sel_bit1,
  output logic conv_start,
  output logic cal_start,
  output logic sh_mode,
  output logic power_down,
  output logic latch_mode,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  input wire logic cal_done,
  input wire logic cal_overflow,
  input wire logic power_fail
);

  // Whole module state
  typedef struct packed {
    ahbc_pkg::ahbc_phase_e phase;
    ahbc_pkg::ahbc_bus_s bus_prev;
    logic [7:0] data_out;
    logic data_oe;
    logic busy_b;
    logic conv_start;
    logic cal_start;
    logic [1:0] channel;
    logic [11:0] result;
    logic latch_mode;
    logic sh_mode;
    logic power_down;
    logic pf_flag;
    logic cal_err;
  } ahbc_state_s;

  localparam ahbc_state_s STATE_RESET = '{
    phase: ahbc_pkg::AHBC_IDLE,
    bus_prev: ahbc_pkg::BUS_RESET,
    data_out: ahbc_pkg::DATA_RESET,
    data_oe: 1'b0,
    busy_b: 1'b1,
    conv_start: 1'b0,
    cal_start: 1'b0,
    channel: ahbc_pkg::CHAN_RESET,
    result: ahbc_pkg::RESULT_RESET,
    latch_mode: 1'b0,
    sh_mode: 1'b0,
    power_down: 1'b0,
    pf_flag: 1'b0,
    cal_err: 1'b0
  };

  logic [1:0] rst_sync_reg; // Reset release chain
  logic rst_int_b; // Synchronised reset
  ahbc_state_s state_reg; // Registered state
  ahbc_state_s state_next; // Next state
  ahbc_pkg::ahbc_bus_s bus_raw; // Pins gathered
  ahbc_pkg::ahbc_bus_s bus_now; // Pins after synchroniser

  // Reset asserts at once and releases through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync_reg[1];

  // Gather pins for the synchroniser
  assign bus_raw = '{cs_b: cs_b, rd_b: rd_b, wr_b: wr_b,
                     register_select: register_select, byte_select: byte_select,
                     cal_b: cal_b, power_fail: power_fail, data: data_in};

  // Bring the bus, calibrate and supply-fail pins into the clock domain; core handshake inputs are used directly
  // Chain starts at the idle levels, matching the reset bus history
  ahbc_sync #(.WIDTH(ahbc_pkg::BUS_WIDTH), .RESET_VALUE(ahbc_pkg::BUS_RESET)) u_sync (
    .clk(clk),
    .rst_b(rst_int_b),
    .din(bus_raw),
    .dout(bus_now)
  );

  // Next-state logic
  always_comb begin
    logic wr_rise;
    logic cal_fall;
    logic pf_rise;
    logic idle;
    ahbc_pkg::ahbc_bus_s p;
    wr_rise = 1'b0;
    cal_fall = 1'b0;
    pf_rise = 1'b0;
    idle = 1'b0;
    p = state_reg.bus_prev;
    state_next = state_reg;
    state_next.bus_prev = bus_now;
    state_next.conv_start = 1'b0;
    state_next.cal_start = 1'b0;
    // Write edge qualified by the lines held during the strobe
    wr_rise = !p.wr_b && bus_now.wr_b && !p.cs_b && p.rd_b && p.cal_b;
    cal_fall = p.cal_b && !bus_now.cal_b;
    pf_rise = !p.power_fail && bus_now.power_fail;
    idle = (state_reg.phase == ahbc_pkg::AHBC_IDLE);

    // Finish running work
    case (state_reg.phase)
      ahbc_pkg::AHBC_IDLE: begin
        // Nothing running
      end
      ahbc_pkg::AHBC_CONV: begin
        // Store the result on completion
        if (conv_done) begin
          state_next.result = conv_result;
          state_next.phase = ahbc_pkg::AHBC_IDLE;
        end
      end
      ahbc_pkg::AHBC_CAL: begin
        // Record overflow on completion
        if (cal_done) begin
          state_next.cal_err = cal_overflow;
          state_next.phase = ahbc_pkg::AHBC_IDLE;
        end
      end
      default: begin
        state_next.phase = ahbc_pkg::AHBC_IDLE;
      end
    endcase

    // Host writes, refused while busy
    if (wr_rise && idle) begin
      if (!p.register_select) begin
        // Plain write: take channel, then convert unless sample/hold
        state_next.channel = p.data[1:0];
        if (!state_reg.sh_mode) begin
          state_next.conv_start = 1'b1;
          state_next.phase = ahbc_pkg::AHBC_CONV;
        end
      end else if (p.byte_select) begin
        // Register write
        state_next.latch_mode = p.data[ahbc_pkg::REG_LATCH_BIT];
        state_next.sh_mode = p.data[ahbc_pkg::REG_SH_BIT];
        state_next.power_down = p.data[ahbc_pkg::REG_PDN_BIT];
        if (!p.data[ahbc_pkg::REG_PF_BIT]) begin
          state_next.pf_flag = 1'b0;
        end
        if (p.data[ahbc_pkg::REG_CAL_BIT]) begin
          // Calibrate request leaves power down only when the power-down bit is written clear
          state_next.cal_start = 1'b1;
          state_next.cal_err = 1'b0;
          state_next.phase = ahbc_pkg::AHBC_CAL;
          if (!p.data[ahbc_pkg::REG_PDN_BIT]) begin
            state_next.power_down = 1'b0;
          end
        end else if (!p.data[ahbc_pkg::REG_SH_BIT]) begin
          state_next.conv_start = 1'b1;
          state_next.phase = ahbc_pkg::AHBC_CONV;
        end
      end
      // Reserved pair: ignored
    end

    // Calibrate pin wins over any start, running work and the power-down bit; a same-cycle write still sets channel and modes
    if (cal_fall) begin
      state_next.cal_start = 1'b1;
      state_next.conv_start = 1'b0;
      state_next.cal_err = 1'b0;
      state_next.power_down = 1'b0;
      state_next.phase = ahbc_pkg::AHBC_CAL;
    end

    // Supply failure sets the flag; set beats a same-cycle clear
    if (pf_rise) begin
      state_next.pf_flag = 1'b1;
    end

    // Busy low while work runs or is being started
    state_next.busy_b = (state_next.phase == ahbc_pkg::AHBC_IDLE);

    // Read decode drives the bus only on a live read
    state_next.data_oe = !bus_now.cs_b && !bus_now.rd_b && bus_now.wr_b
                         && bus_now.cal_b;
    if (!bus_now.register_select) begin
      if (bus_now.byte_select) begin
        state_next.data_out = {4'h0, state_reg.result[11:8]};
      end else begin
        state_next.data_out = state_reg.result[7:0];
      end
    end else if (bus_now.byte_select) begin
      // Register contents with status in the top bits
      state_next.data_out = 8'h00;
      state_next.data_out[ahbc_pkg::REG_BUSY_BIT] = !idle;
      state_next.data_out[ahbc_pkg::REG_CALERR_BIT] = state_reg.cal_err;
      state_next.data_out[ahbc_pkg::REG_PF_BIT] = state_reg.pf_flag;
      state_next.data_out[ahbc_pkg::REG_PDN_BIT] = state_reg.power_down;
      state_next.data_out[ahbc_pkg::REG_SH_BIT] = state_reg.sh_mode;
      state_next.data_out[ahbc_pkg::REG_LATCH_BIT] = state_reg.latch_mode;
    end else begin
      // Reserved read returns zero
      state_next.data_out = 8'h00;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign data_out = state_reg.data_out;
  assign data_oe = state_reg.data_oe;
  assign busy_b = state_reg.busy_b;
  assign channel_sel_bit0 = state_reg.channel[0];
  assign channel_sel_bit1 = state_reg.channel[1];
  assign conv_start = state_reg.conv_start;
  assign cal_start = state_reg.cal_start;
  assign sh_mode = state_reg.sh_mode;
  assign power_down = state_reg.power_down;
  assign latch_mode = state_reg.latch_mode;

endmodule : ahbc_host_port

// ### rtl/ahbc_pkg.sv
package ahbc_pkg;

  // Bit positions of the special function register
  localparam int REG_LATCH_BIT = 0;
  localparam int REG_CAL_BIT = 1;
  localparam int REG_SH_BIT = 2;
  localparam int REG_PDN_BIT = 3;
  localparam int REG_PF_BIT = 5;
  localparam int REG_CALERR_BIT = 6;
  localparam int REG_BUSY_BIT = 7;

  // Values after reset
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  // Synchroniser depth, in flip-flops
  localparam int SYNC_STAGES = 2;

  // Sequencer phases
  typedef enum logic [1:0] {
    AHBC_IDLE = 2'b00,
    AHBC_CONV = 2'b01,
    AHBC_CAL = 2'b10
  } ahbc_phase_e;

  // Control lines and data bus as sampled from the pins
  typedef struct packed {
    logic cs_b;
    logic rd_b;
    logic wr_b;
    logic register_select;
    logic byte_select;
    logic cal_b;
    logic power_fail;
    logic [7:0] data;
  } ahbc_bus_s;

  localparam int BUS_WIDTH = $bits(ahbc_bus_s);

  // Bus sample after reset: all strobes idle high
  localparam ahbc_bus_s BUS_RESET = '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1,
                                      register_select: 1'b0, byte_select: 1'b0,
                                      cal_b: 1'b1, power_fail: 1'b0, data: 8'h00};

endpackage : ahbc_pkg

// ### rtl/ahbc_sync.sv
`timescale 1ns/1ps
module ahbc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0 // Idle pin levels, so no false edge after reset
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // Two-flop chain per bit; only the second flop is seen outside
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [ahbc_pkg::SYNC_STAGES-1:0] stage_reg;
    // Shift the pin level through the chain
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        stage_reg <= {ahbc_pkg::SYNC_STAGES{RESET_VALUE[i]}};
      end else begin
        stage_reg <= {stage_reg[ahbc_pkg::SYNC_STAGES-2:0], din[i]};
      end
    end
    assign dout[i] = stage_reg[ahbc_pkg::SYNC_STAGES-1];
  end

endmodule : ahbc_sync

// ### tb/ahbc_host_port_properties.sv
`timescale 1ns/1ps
// Timing checks on the host port pins
module ahbc_host_port_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic data_oe,
  input wire logic busy_b,
  input wire logic conv_start,
  input wire logic cal_start,
  input wire logic conv_done,
  input wire logic channel_sel_bit0,
  input wire logic channel_sel_bit1
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Start pulses and busy
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  busy_conv_a: assert property (conv_start |-> !busy_b && $past(busy_b))
    else $error("start while busy or busy not low");
  busy_cal_a: assert property (cal_start |-> !busy_b)
    else $error("busy not low on calibration");
  busy_cause_a: assert property ($fell(busy_b) |-> conv_start || cal_start)
    else $error("busy fell without a start");
  busy_end_a: assert property (conv_done && !cal_start |=> busy_b)
    else $error("busy not released after done");
  // Channel frozen while working
  chan_hold_a: assert property (!busy_b && !$past(busy_b) |->
    $stable({channel_sel_bit1, channel_sel_bit0})) else $error("channel moved");
  // Bus drive only after a select
  bus_release_a: assert property (cs_b [*5] |=> !data_oe)
    else $error("bus driven while deselected");
  oe_cause_a: assert property (data_oe |-> !$past(cs_b, 2) || !$past(cs_b, 3))
    else $error("bus driven without select");
  cover property (conv_start);
  cover property (cal_start);
  cover property (data_oe);
endmodule : ahbc_host_port_properties

bind ahbc_host_port ahbc_host_port_properties u_ahbc_host_port_properties (.clk(clk),
  .rst_b(rst_b), .cs_b(cs_b), .data_oe(data_oe), .busy_b(busy_b), .conv_start(conv_start),
  .cal_start(cal_start), .conv_done(conv_done), .channel_sel_bit0(channel_sel_bit0),
  .channel_sel_bit1(channel_sel_bit1));

// ### tb/ahbc_host_model.sv
`timescale 1ns/1ps
// Host processor on the parallel bus
module ahbc_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic cs_b,
  output logic rd_b,
  output logic wr_b,
  output logic register_select,
  output logic byte_select,
  output logic [7:0] data_in
);
  logic oe_seen; // Bus drive seen at the end of the last access
  initial begin
    {cs_b, rd_b, wr_b, register_select, byte_select} = 5'h1c;
    data_in = 8'h00;
    oe_seen = 1'b0;
  end
  // One access; strobes high 3 cycles before, low 5 cycles
  task automatic cyc(input logic wr, input logic rs, input logic bs, input logic [7:0] d,
                     output logic [7:0] q);
    repeat (3) @(posedge clk);
    #2;
    // Reserved pair never issued: register select always comes with byte select
    {register_select, byte_select} = {rs, rs | bs};
    // Channel on the low data lines; undriven bus shows no stale value
    data_in = wr ? d : ~data_in;
    {cs_b, rd_b, wr_b} = {1'b0, wr, !wr};
    repeat (5) @(posedge clk);
    #2;
    q = data_out;
    oe_seen = data_oe;
    {cs_b, rd_b, wr_b} = 3'h7;
    data_in = ~data_in;
  endtask : cyc
endmodule : ahbc_host_model

// ### tb/test_adc_host_bus_control.sv
`timescale 1ns/1ps
module test_adc_host_bus_control;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cal_b = 1'b1;
  logic conv_done = 1'b0;
  logic cal_done = 1'b0;
  logic cal_overflow = 1'b0;
  logic power_fail = 1'b0;
  logic [11:0] conv_result = 12'habc; // Core result
  logic cs_b, rd_b, wr_b, register_select, byte_select, data_oe, busy_b, ch0, ch1;
  logic conv_start, cal_start, sh_mode, power_down, latch_mode;
  logic [7:0] data_in, data_out, q;
  int num_errors = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  ahbc_host_port u_ahbc_host_port (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b),
    .wr_b(wr_b), .register_select(register_select), .byte_select(byte_select), .cal_b(cal_b),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .busy_b(busy_b),
    .channel_sel_bit0(ch0), .channel_sel_bit1(ch1), .conv_start(conv_start),
    .cal_start(cal_start), .sh_mode(sh_mode), .power_down(power_down),
    .latch_mode(latch_mode), .conv_done(conv_done), .conv_result(conv_result),
    .cal_done(cal_done), .cal_overflow(cal_overflow), .power_fail(power_fail));
  ahbc_host_model u_ahbc_host_model (.clk(clk), .data_out(data_out), .data_oe(data_oe), .cs_b(cs_b),
    .rd_b(rd_b), .wr_b(wr_b), .register_select(register_select), .byte_select(byte_select),
    .data_in(data_in));
  task automatic end_sim;
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Bounded wait for a start pulse, sel high for calibration
  task automatic wait_go(input logic sel);
    int i;
    for (i = 0; i < 20 && (sel ? cal_start : conv_start) !== 1'b1; i++) @(posedge clk) #2;
    chk("start", 8'h01, {7'h0, i < 20});
    if (i >= 20) begin
      end_sim();
    end else begin
      chk("busy_b", 8'h00, {7'h0, busy_b});
    end
  endtask : wait_go
  // No conversion may start for 12 cycles
  task automatic no_go;
    repeat (12) @(posedge clk) #2 chk("no start", 8'h00, {7'h0, conv_start});
  endtask : no_go
  // Core finishes the running job
  task automatic done(input logic sel);
    @(posedge clk) #2 {cal_done, conv_done} = {sel, !sel};
    @(posedge clk) #2 {cal_done, conv_done} = 2'h0;
    @(posedge clk) #2 chk("busy_b end", 8'h01, {7'h0, busy_b});
  endtask : done
  // Conversion, refused restart, both result bytes
  task automatic t_conv;
    u_ahbc_host_model.cyc(1'b1, 1'b0, 1'b0, 8'h02, q);
    wait_go(1'b0);
    chk("channel", 8'h02, {6'h0, ch1, ch0});
    u_ahbc_host_model.cyc(1'b1, 1'b0, 1'b0, 8'h01, q);
    no_go();
    chk("channel held", 8'h02, {6'h0, ch1, ch0});
    done(1'b0);
    u_ahbc_host_model.cyc(1'b0, 1'b0, 1'b0, 8'h00, q);
    chk("low byte", 8'hbc, q);
    chk("read oe", 8'h01, {7'h0, u_ahbc_host_model.oe_seen});
    u_ahbc_host_model.cyc(1'b0, 1'b0, 1'b1, 8'h00, q);
    chk("high byte", 8'h0a, q);
  endtask : t_conv
  // Register modes, readback, plain register write starts
  task automatic t_reg;
    u_ahbc_host_model.cyc(1'b1, 1'b1, 1'b1, 8'h0d, q);
    no_go();
    chk("modes", 8'h07, {5'h0, power_down, sh_mode, latch_mode});
    u_ahbc_host_model.cyc(1'b0, 1'b1, 1'b1, 8'h00, q);
    chk("register", 8'h0d, q);
    u_ahbc_host_model.cyc(1'b1, 1'b1, 1'b1, 8'h00, q);
    wait_go(1'b0);
    chk("modes off", 8'h00, {5'h0, power_down, sh_mode, latch_mode});
    done(1'b0);
  endtask : t_reg
  // Calibrate pin, status flags, bus release
  task automatic t_cal;
    cal_b = 1'b0;
    wait_go(1'b1);
    cal_b = 1'b1;
    u_ahbc_host_model.cyc(1'b0, 1'b1, 1'b1, 8'h00, q);
    chk("status busy", 8'h80, q);
    cal_overflow = 1'b1;
    power_fail = 1'b1;
    done(1'b1);
    cal_overflow = 1'b0;
    power_fail = 1'b0;
    u_ahbc_host_model.cyc(1'b0, 1'b1, 1'b1, 8'h00, q);
    chk("status flags", 8'h60, q);
    // Sample/hold on, fail flag cleared, no start; error flag stays
    u_ahbc_host_model.cyc(1'b1, 1'b1, 1'b1, 8'h04, q);
    u_ahbc_host_model.cyc(1'b0, 1'b1, 1'b1, 8'h00, q);
    chk("flag clear", 8'h44, q);
    repeat (6) @(posedge clk);
    #2 chk("released", 8'h00, {7'h0, data_oe});
  endtask : t_cal
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #2 rst_b = 1'b1;
    repeat (8) @(posedge clk);
    #2;
    chk("idle oe", 8'h00, {7'h0, data_oe});
    chk("idle busy_b", 8'h01, {7'h0, busy_b});
    t_conv();
    t_reg();
    t_cal();
    end_sim();
  end
endmodule : test_adc_host_bus_control
